// >>> rtl/capture_pkg.sv
// Purpose: Shared constants for the two-channel event capture unit.
// Assumes: One 40 MHz clock, AHB-Lite register access, word-aligned registers.
// Notes:   Register offsets are byte addresses; channel 1 sits one stride above channel 0.
// Summary of operation
// - Arming a channel clears its captured flag until the next qualifying event.
// - Captured flag reads one after capture, zero when not captured or disarmed.
// - Time mode stores an unsigned 32-bit nanosecond value in a read-only register.
// - Timestamp counts from the latest servo-cycle sync pulse, nominally every 62.5 us.
// - Selector 0-6 general inputs, 7-9 differential, 10 primary, 11 tertiary index.
// - Selector is writable, 8 bits, values 0 to 11, reset value 0.
// - Captured-value select 0 gives position capture, 1 gives time capture.
// - Edge detection resolves simultaneity to one 25 ns clock tick.
`default_nettype none

package capture_pkg;
    // Clock and time base
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned NS_PER_SEC      = 1_000_000_000;
    localparam logic [31:0] NS_PER_CYCLE    = 32'(NS_PER_SEC / CLK_HZ);
    localparam logic [31:0] TIME_MAX        = 32'hffff_ffff;
    localparam logic [31:0] TIME_RST        = 32'h0000_0000;

    // Channels and trigger sources
    localparam int unsigned NUM_CH          = 2;
    localparam int unsigned NUM_GEN         = 7;
    localparam int unsigned NUM_DIFF        = 3;
    localparam int unsigned NUM_SRC         = 12;
    localparam int unsigned SEL_W           = 8;
    localparam logic [7:0]  SEL_MAX         = 8'h0b;
    localparam logic [7:0]  TRIG_RST        = 8'h00;

    // Captured-value modes
    localparam logic [7:0]  MODE_POSITION   = 8'h00;
    localparam logic [7:0]  MODE_TIME       = 8'h01;
    localparam logic [7:0]  MODE_RST        = 8'h00;

    // Register map
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  CH_STRIDE       = 8'h20;
    localparam logic [7:0]  OFF_CTRL        = 8'h00;
    localparam logic [7:0]  OFF_TRIG        = 8'h04;
    localparam logic [7:0]  OFF_STAT        = 8'h08;
    localparam logic [7:0]  OFF_TIME        = 8'h0c;
    localparam logic [7:0]  OFF_POS         = 8'h10;
    localparam logic [7:0]  OFF_IRQ_STAT    = 8'h40;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h44;

    // Field positions
    localparam int unsigned CTRL_ARM_BIT    = 0;
    localparam int unsigned CTRL_MODE_LSB   = 8;
    localparam int unsigned STAT_DONE_BIT   = 0;

    // Bus encodings
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic        HRESP_OKAY      = 1'h0;
endpackage : capture_pkg

`default_nettype wire

// >>> rtl/servo_cycle_timer.sv
// Purpose: Nanosecond time base restarted by every servo-cycle sync pulse.
// Assumes: Sync pulse is a one-cycle pulse synchronous to hclk.
// Notes:   Saturates instead of wrapping if sync pulses stop.
`default_nettype none

module servo_cycle_timer (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Cycle reference
    input  wire logic        servo_cycle_sync_pulse,
    // Time since last sync
    output logic      [31:0] time_ns
);
    import capture_pkg::*;

    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic        at_max;

    // Wrapping would fake a small time after a lost sync
    assign at_max    = (count_r > (TIME_MAX - NS_PER_CYCLE));
    assign count_nxt = servo_cycle_sync_pulse ? TIME_RST :
                       at_max ? TIME_MAX : (count_r + NS_PER_CYCLE);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r <= TIME_RST;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign time_ns = count_r;
endmodule : servo_cycle_timer

`default_nettype wire

// >>> rtl/capture_channel.sv
// Purpose: One capture channel: source select, edge detect, one-shot latch.
// Assumes: Sources are synchronous to hclk and already filtered.
// Notes:   A source change while armed may look like an edge; select before arming.
`default_nettype none

module capture_channel (
    // Clock and reset
    input  wire logic                               hclk,
    input  wire logic                               hresetn,
    // Trigger sources and selection
    input  wire logic [capture_pkg::NUM_SRC-1:0]    src_in,
    input  wire logic [capture_pkg::SEL_W-1:0]      src_sel,
    // Control
    input  wire logic                               arm,
    input  wire logic                               arm_clear,
    input  wire logic                               time_mode,
    // Values to capture
    input  wire logic [31:0]                        time_ns,
    input  wire logic [31:0]                        position_in,
    // Results
    output logic                                    done,
    output logic                                    event_pulse,
    output logic      [31:0]                        time_val,
    output logic      [31:0]                        pos_val
);
    import capture_pkg::*;

    logic        sel_level;
    logic        prev_r;
    logic        rise;
    logic        hit;
    logic        done_r;
    logic [31:0] time_r;
    logic [31:0] pos_r;

    assign sel_level = (src_sel <= SEL_MAX) ? src_in[src_sel[3:0]] : 1'b0;
    assign rise      = sel_level & ~prev_r;
    assign hit       = arm & ~done_r & rise & ~arm_clear;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= sel_level;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_r <= 1'b0;
        end else if (arm_clear) begin
            done_r <= 1'b0;
        end else if (hit) begin
            done_r <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            time_r <= TIME_RST;
            pos_r  <= 32'h0000_0000;
        end else if (hit) begin
            if (time_mode) begin
                time_r <= time_ns;
            end else begin
                pos_r  <= position_in;
            end
        end
    end

    assign done        = done_r & arm;
    assign event_pulse = hit;
    assign time_val    = time_r;
    assign pos_val     = pos_r;
endmodule : capture_channel

`default_nettype wire

// >>> rtl/capture_unit.sv
// Purpose: Two-channel event capture unit with AHB-Lite register access.
// Assumes: All trigger inputs and the sync pulse are synchronous to hclk.
// Notes:   Reads take one wait state; writes take none. Response is always OKAY.
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`default_nettype none

module capture_unit (
    // AHB-Lite clock and reset
    input  wire logic                               hclk,
    input  wire logic                               hresetn,
    // AHB-Lite slave
    input  wire logic                               hsel,
    input  wire logic [31:0]                        haddr,
    input  wire logic [1:0]                         htrans,
    input  wire logic                               hwrite,
    input  wire logic [2:0]                         hsize,
    input  wire logic [31:0]                        hwdata,
    input  wire logic                               hready,
    output logic                                    hreadyout,
    output logic                                    hresp,
    output logic      [31:0]                        hrdata,
    // Trigger sources
    input  wire logic [capture_pkg::NUM_GEN-1:0]    gen_in,
    input  wire logic [capture_pkg::NUM_DIFF-1:0]   diff_in,
    input  wire logic                               index_primary,
    input  wire logic                               index_tertiary,
    // Cycle reference and position feedback
    input  wire logic                               servo_cycle_sync_pulse,
    input  wire logic [31:0]                        position_in,
    // Interrupt
    output logic                                    irq
);
    import capture_pkg::*;

    // Bus data-phase state
    logic                  wr_pend_r;
    logic                  rd_pend_r;
    logic [ADDR_W-1:0]     addr_r;
    logic [31:0]           hrdata_r;
    logic                  addr_take;

    // Per-channel control and status
    logic [NUM_CH-1:0]     arm_r;
    logic [7:0]            mode_r    [NUM_CH];
    logic [7:0]            trig_r    [NUM_CH];
    logic [NUM_CH-1:0]     arm_clear;
    logic [NUM_CH-1:0]     done;
    logic [NUM_CH-1:0]     event_pulse;
    logic [31:0]           time_val  [NUM_CH];
    logic [31:0]           pos_val   [NUM_CH];
    logic [31:0]           ch_rdata  [NUM_CH];
    logic [31:0]           ch_or     [NUM_CH+1];

    // Interrupt registers
    logic [NUM_CH-1:0]     irq_stat_r;
    logic [NUM_CH-1:0]     irq_stat_nxt;
    logic [NUM_CH-1:0]     irq_mask_r;
    logic                  wr_irq_stat;
    logic                  wr_irq_mask;
    logic [31:0]           irq_rdata;
    logic [31:0]           rdata_mux;

    // Shared time base and source vector
    logic [31:0]           time_ns;
    logic [NUM_SRC-1:0]    src_vec;

    // Bit order of the source vector is the selector's value
    assign src_vec = {index_tertiary, index_primary, diff_in, gen_in};

    //------------------------------------------------------------
    // Bus slave
    //------------------------------------------------------------
    assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
        end else begin
            wr_pend_r <= addr_take & hwrite;
        end
    end

    // A read holds the bus one cycle so its data comes from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= addr_take & ~hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= '0;
        end else if (addr_take) begin
            addr_r <= haddr[ADDR_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            hrdata_r <= rdata_mux;
        end
    end

    assign hreadyout = ~rd_pend_r;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_r;

    //------------------------------------------------------------
    // Shared nanosecond time base
    //------------------------------------------------------------
    servo_cycle_timer u_timer (
        .hclk                   (hclk),
        .hresetn                (hresetn),
        .servo_cycle_sync_pulse (servo_cycle_sync_pulse),
        .time_ns                (time_ns)
    );

    //------------------------------------------------------------
    // Channels
    //------------------------------------------------------------
    assign ch_or[0] = 32'h0000_0000;

    genvar c;
    generate
        for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
            localparam logic [ADDR_W-1:0] BASE = ADDR_W'(c * CH_STRIDE);

            logic wr_ctrl;
            logic wr_trig;
            logic trig_ok;
            logic hit_ctrl;
            logic hit_trig;
            logic hit_stat;
            logic hit_time;
            logic hit_pos;

            assign hit_ctrl = (addr_r == (BASE + OFF_CTRL));
            assign hit_trig = (addr_r == (BASE + OFF_TRIG));
            assign hit_stat = (addr_r == (BASE + OFF_STAT));
            assign hit_time = (addr_r == (BASE + OFF_TIME));
            assign hit_pos  = (addr_r == (BASE + OFF_POS));

            assign wr_ctrl  = wr_pend_r & hit_ctrl;
            assign wr_trig  = wr_pend_r & hit_trig;
            // Out-of-range selectors are dropped, keeping the old source
            assign trig_ok  = (hwdata[7:0] <= SEL_MAX);

            // Only a 0-to-1 write of the arm bit restarts the channel
            assign arm_clear[c] = wr_ctrl & hwdata[CTRL_ARM_BIT] & ~arm_r[c];

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    arm_r[c]  <= 1'b0;
                    mode_r[c] <= MODE_RST;
                end else if (wr_ctrl) begin
                    arm_r[c]  <= hwdata[CTRL_ARM_BIT];
                    mode_r[c] <= hwdata[CTRL_MODE_LSB +: 8];
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    trig_r[c] <= TRIG_RST;
                end else if (wr_trig && trig_ok) begin
                    trig_r[c] <= hwdata[7:0];
                end
            end

            capture_channel u_ch (
                .hclk        (hclk),
                .hresetn     (hresetn),
                .src_in      (src_vec),
                .src_sel     (trig_r[c]),
                .arm         (arm_r[c]),
                .arm_clear   (arm_clear[c]),
                .time_mode   (mode_r[c] == MODE_TIME),
                .time_ns     (time_ns),
                .position_in (position_in),
                .done        (done[c]),
                .event_pulse (event_pulse[c]),
                .time_val    (time_val[c]),
                .pos_val     (pos_val[c])
            );

            assign ch_rdata[c] =
                hit_ctrl ? {16'h0000, mode_r[c], 7'h00, arm_r[c]} :
                hit_trig ? {24'h00_0000, trig_r[c]} :
                hit_stat ? {31'h0000_0000, done[c]} :
                hit_time ? time_val[c] :
                hit_pos  ? pos_val[c] : 32'h0000_0000;

            assign ch_or[c+1] = ch_or[c] | ch_rdata[c];
        end
    endgenerate

    //------------------------------------------------------------
    // Interrupts
    //------------------------------------------------------------
    assign wr_irq_stat = wr_pend_r & (addr_r == OFF_IRQ_STAT);
    assign wr_irq_mask = wr_pend_r & (addr_r == OFF_IRQ_MASK);

    // A capture in the clearing cycle stays set
    assign irq_stat_nxt = (irq_stat_r & ~(wr_irq_stat ? hwdata[NUM_CH-1:0] : '0)) | event_pulse;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_r <= '0;
        end else if (wr_irq_mask) begin
            irq_mask_r <= hwdata[NUM_CH-1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    assign irq_rdata =
        (addr_r == OFF_IRQ_STAT) ? {{(32-NUM_CH){1'b0}}, irq_stat_r} :
        (addr_r == OFF_IRQ_MASK) ? {{(32-NUM_CH){1'b0}}, irq_mask_r} : 32'h0000_0000;

    // Unmapped addresses read zero
    assign rdata_mux = ch_or[NUM_CH] | irq_rdata;
endmodule : capture_unit

`default_nettype wire

// >>> tb/capture_unit_checker.sv
// Purpose: Port-level assertions for the capture unit.
// Assumes: hready is tied to hreadyout (single slave).
// Notes:   Sees only the top module's ports.
`default_nettype none

module capture_unit_checker
    import capture_pkg::*;
(
    input wire logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic                index_primary, index_tertiary, servo_cycle_sync_pulse, irq,
    input wire logic [31:0]         haddr, hwdata, hrdata, position_in,
    input wire logic [1:0]          htrans,
    input wire logic [2:0]          hsize,
    input wire logic [NUM_GEN-1:0]  gen_in,
    input wire logic [NUM_DIFF-1:0] diff_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        wr_r, rd_r, rise_r;
    logic [7:0]  adr_r;
    logic [11:0] src_r;
    wire         taken = hsel && hready && htrans == HTRANS_NONSEQ;
    wire  [11:0] srcs = {index_tertiary, index_primary, diff_in, gen_in};
    wire         rd_end = rd_r && !hreadyout;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_r, rd_r, rise_r, adr_r, src_r} <= '0;
        end else begin
            if (hready) begin
                wr_r <= taken && hwrite;
                rd_r <= taken && !hwrite;
            end
            if (taken) begin
                adr_r <= haddr[7:0];
            end
            src_r <= srcs;
            rise_r <= |(srcs & ~src_r);
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_resp; hresp == HRESP_OKAY; endproperty
    a_resp: assert property (p_resp) else $error("hresp not OKAY");
    property p_rd_wait; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_nowait; taken && hwrite |=> hreadyout; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_one_wait; !hreadyout |=> hreadyout; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
    property p_hold; hreadyout |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("hrdata changed outside read");
    property p_stat; rd_end && (adr_r == OFF_STAT || adr_r == CH_STRIDE + OFF_STAT) |=> hrdata[31:1] == '0;
    endproperty
    a_stat: assert property (p_stat) else $error("status upper bits set");
    property p_trig; rd_end && adr_r[4:0] == OFF_TRIG[4:0] && adr_r < OFF_IRQ_STAT |=> hrdata[31:4] == '0;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger select out of range");
    property p_irq_rise; $rose(irq) |-> rise_r || $past(wr_r); endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall; $fell(irq) |-> $past(wr_r); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
    c_rd: cover property (rd_end);
    c_wr: cover property (wr_r);
    c_irq: cover property ($rose(irq));
endmodule : capture_unit_checker

`default_nettype wire

// >>> tb/trigger_source_model.sv
// Purpose: Model of the trigger inputs, sync pulse and position feedback.
// Assumes: All outputs synchronous to hclk.
// Notes:   Sync restartable so a test can align an edge to it.
`default_nettype none

module trigger_source_model #(
    parameter int SYNC_CYCLES = 2500
) (
    input  wire logic        hclk,
    output logic [6:0]       gen_in,
    output logic [2:0]       diff_in,
    output logic             index_primary,
    output logic             index_tertiary,
    output logic             servo_cycle_sync_pulse,
    output logic [31:0]      position_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] src_r = 12'h000;
    logic        resync = 1'b0;
    logic        sync_r = 1'b0;
    logic [31:0] pos_r = 32'h0000_0000;
    logic [31:0] pos_hit = 32'h0000_0000;
    int          cnt = 0;
    assign {index_tertiary, index_primary, diff_in, gen_in} = src_r;
    assign servo_cycle_sync_pulse = sync_r;
    assign position_in = pos_r;
    always @(posedge hclk) begin
        pos_r <= pos_r + 32'h0000_0003;
        sync_r <= resync || cnt == SYNC_CYCLES - 1;
        cnt <= (resync || cnt == SYNC_CYCLES - 1) ? 0 : cnt + 1;
    end
    // Rising edge on source s, gap cycles after a fresh sync when gap > 0
    task automatic fire(input int s, input int gap);
        @(posedge hclk);
        if (gap > 0) begin
            resync <= 1'b1;
            @(posedge hclk);
            resync <= 1'b0;
            repeat (gap) @(posedge hclk);
        end
        src_r[s] <= 1'b1;
        // Position the design latches at the next edge
        pos_hit = pos_r + 32'h0000_0003;
        repeat (2) @(posedge hclk);
        src_r[s] <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask : fire
endmodule : trigger_source_model

`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the capture unit.
// Assumes: Single AHB-Lite slave, hready taken from hreadyout.
// Notes:   Expected times counted from the model's sync restart.
`default_nettype none

module testbench
    import capture_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic        hreadyout, hresp, irq, idx_p, idx_t, sync;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, pos;
    logic [6:0]  gen_in;
    logic [2:0]  diff_in;
    int          err_total = 0, check_count = 0;
    always #12.5 hclk = ~hclk;
    trigger_source_model #(.SYNC_CYCLES(2500)) i_src (.hclk(hclk), .gen_in(gen_in), .diff_in(diff_in),
        .index_primary(idx_p), .index_tertiary(idx_t), .servo_cycle_sync_pulse(sync), .position_in(pos));
    capture_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .gen_in(gen_in), .diff_in(diff_in), .index_primary(idx_p),
        .index_tertiary(idx_t), .servo_cycle_sync_pulse(sync), .position_in(pos), .irq(irq));
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
        check_count++;
        if (got !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask : check
    task automatic xfer(input logic w, input logic [7:0] a, inout logic [31:0] d);
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        xfer(1'b1, a, v);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] v = 32'h0;
        xfer(1'b0, a, v);
        check(what, e, v);
    endtask : rd_chk
    // Re-arm needs arm low first, otherwise the flag is kept
    task automatic arm(input logic [7:0] b, input logic [31:0] mode);
        wr(b + OFF_CTRL, 32'h0);
        wr(b + OFF_CTRL, mode | 32'h1);
    endtask : arm
    task automatic t_reset;
        check("irq", 32'h0, {31'h0, irq});
        rd_chk(OFF_TRIG, 32'h0, "trig0");
        rd_chk(CH_STRIDE + OFF_TRIG, 32'h0, "trig1");
        rd_chk(OFF_STAT, 32'h0, "stat0");
        rd_chk(8'h3c, 32'h0, "unmapped");
        for (int v = 0; v < 13; v++) begin
            wr(OFF_TRIG, 32'(v));
            rd_chk(OFF_TRIG, v < 12 ? 32'(v) : 32'h0000_000b, "trig");
        end
    endtask : t_reset
    task automatic t_map;
        logic [7:0] b;
        for (int s = 0; s < 12; s++) begin
            b = (s % 2 == 1) ? CH_STRIDE : 8'h00;
            wr(b + OFF_TRIG, 32'(s));
            arm(b, 32'h0);
            rd_chk(b + OFF_STAT, 32'h0, "stat armed");
            i_src.fire((s + 1) % 12, 0);
            rd_chk(b + OFF_STAT, 32'h0, "stat other source");
            i_src.fire(s, 0);
            rd_chk(b + OFF_STAT, 32'h1, "stat captured");
            rd_chk(b + OFF_POS, i_src.pos_hit, "pos captured");
            wr(b + OFF_CTRL, 32'h0);
            rd_chk(b + OFF_STAT, 32'h0, "stat disarmed");
        end
        wr(OFF_IRQ_STAT, 32'h3);
    endtask : t_map
    // Rows: channel, source, gap after sync, re-arm; a row without re-arm must not move the value
    task automatic t_time;
        int          tab [4][4] = '{'{0, 3, 40, 1}, '{0, 3, 7, 0}, '{1, 11, 2, 1}, '{0, 9, 1000, 1}};
        logic [31:0] ex [2];
        logic [7:0]  b;
        foreach (tab[i]) begin
            b = tab[i][0] ? CH_STRIDE : 8'h00;
            if (tab[i][3] != 0) begin
                wr(b + OFF_TRIG, 32'(tab[i][1]));
                arm(b, 32'(MODE_TIME) << CTRL_MODE_LSB);
                ex[tab[i][0]] = NS_PER_CYCLE * 32'(tab[i][2] - 1);
            end
            i_src.fire(tab[i][1], tab[i][2]);
            rd_chk(b + OFF_TIME, ex[tab[i][0]], "time");
        end
    endtask : t_time
    task automatic t_irq;
        wr(OFF_IRQ_STAT, 32'h3);
        wr(OFF_IRQ_MASK, 32'h1);
        wr(OFF_TRIG, 32'h0);
        arm(8'h00, 32'h0);
        arm(CH_STRIDE, 32'h0);
        i_src.fire(0, 0);
        check("irq masked in", 32'h1, {31'h0, irq});
        i_src.fire(11, 0);
        rd_chk(OFF_IRQ_STAT, 32'h3, "irq status");
        wr(OFF_IRQ_STAT, 32'h1);
        @(posedge hclk);
        check("irq masked out", 32'h0, {31'h0, irq});
        wr(OFF_IRQ_MASK, 32'h2);
        @(posedge hclk);
        check("irq unmasked", 32'h1, {31'h0, irq});
        wr(OFF_IRQ_STAT, 32'h2);
        @(posedge hclk);
        check("irq cleared", 32'h0, {31'h0, irq});
    endtask : t_irq
    // Reset in mid-run with a pending interrupt and a non-default selector
    task automatic t_rst2;
        wr(OFF_IRQ_MASK, 32'h3);
        arm(8'h00, 32'h0);
        i_src.fire(0, 0);
        check("irq before reset", 32'h1, {31'h0, irq});
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
    endtask : t_rst2
    task automatic test_done;
        $display("Checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_map();
        t_time();
        t_irq();
        t_rst2();
        test_done();
    end
    initial begin
        repeat (60000) @(posedge hclk);
        err_total++;
        $display("Error watchdog expired");
        test_done();
    end
endmodule : testbench

bind capture_unit capture_unit_checker i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .index_primary(index_primary), .index_tertiary(index_tertiary),
    .servo_cycle_sync_pulse(servo_cycle_sync_pulse), .irq(irq), .haddr(haddr), .hwdata(hwdata),
    .hrdata(hrdata), .position_in(position_in), .htrans(htrans), .hsize(hsize), .gen_in(gen_in),
    .diff_in(diff_in)
);

`default_nettype wire
